// ==== rtl/brs_map.svh ====
// Purpose: Register offsets, field positions, reset values and limits of the brake sequencer.
// Assumes: 16-bit register words, word-indexed addresses on a 4-bit port.
// Notes: Definitions only.
`ifndef BRS_MAP_SVH
`define BRS_MAP_SVH

// Register indices
`define BRS_REG_CTRL 4'h0
`define BRS_REG_STATUS 4'h1
`define BRS_REG_IRQ_STAT 4'h2
`define BRS_REG_IRQ_MASK 4'h3
`define BRS_REG_REL_WAIT 4'h4
`define BRS_REG_ACC_WAIT 4'h5
`define BRS_REG_STOP_WAIT 4'h6
`define BRS_REG_CONF_WAIT 4'h7
`define BRS_REG_REL_FREQ 4'h8
`define BRS_REG_REL_CUR 4'h9
`define BRS_REG_APPLY_FREQ 4'hA
`define BRS_REG_FAULT_CODE 4'hB

// Control fields
`define BRS_CTRL_EN_LO 0
`define BRS_CTRL_EN_HI 1
`define BRS_CTRL_CONF_ASSIGNED 2
`define BRS_CTRL_LARGE_FRAME 3
`define BRS_CTRL_FAULT_CLEAR 4
`define BRS_EN_OFF 2'h0
`define BRS_EN_ON 2'h1

// Status fields (state occupies the low bits)
`define BRS_STAT_RELEASE 11
`define BRS_STAT_CONFIRM 12
`define BRS_STAT_ERROR 13

// Interrupt bits
`define BRS_IRQ_FAULT 0
`define BRS_IRQ_RELEASED 1
`define BRS_IRQ_ENGAGED 2
`define BRS_IRQ_W 3

// Reset values
`define BRS_RST_WORD 16'h0000
`define BRS_RST_CTRL 16'h0000

// Limits: times in 10 ms ticks, frequency in 0.01 Hz, current in 0.1 % of rated
`define BRS_TIME_MAX 9'h1F4
`define BRS_FREQ_MAX 16'h9C40
`define BRS_FREQ_FINE_TOP 16'h2710
`define BRS_FREQ_COARSE_STEP 16'h000A
`define BRS_CUR_MAX 16'h07D0
`define BRS_CUR_MAX_LARGE 16'h0708
`define BRS_FAULT_CODE 8'h24

// Tick timing
`define BRS_TICK_MS 10
`define BRS_CLK_KHZ 40000
`define BRS_TICK_CYCLES (`BRS_TICK_MS * `BRS_CLK_KHZ)
`define BRS_TICK_CNT_W 19

`endif

// ==== rtl/brs_pkg.sv ====
// Purpose: Types shared by the brake sequencer modules.
// Assumes: One-hot sequence states.
// Notes: Constants live in brs_map.svh.
package brs_pkg;
	typedef logic [15:0] brs_word_t;
	typedef logic [3:0] brs_addr_t;
	typedef logic [8:0] brs_time_t;
	typedef enum logic [10:0] {
		ST_IDLE = 11'h001,
		ST_ACC_REL = 11'h002,
		ST_REL_WAIT = 11'h004,
		ST_CONF_ON = 11'h008,
		ST_ACC_WAIT = 11'h010,
		ST_RUN = 11'h020,
		ST_DEC_APPLY = 11'h040,
		ST_CONF_OFF = 11'h080,
		ST_STOP_WAIT = 11'h100,
		ST_DEC_ZERO = 11'h200,
		ST_FAULT = 11'h400
	} brs_state_t;
endpackage : brs_pkg

// ==== rtl/brs_seq.sv ====
// Purpose: Brake release sequencer of a motor drive with register port and interrupt.
// Assumes: run_cmd, out_freq, out_current come from drive logic on core_clk.
// Notes: brake_confirm_in is a pin and is synchronised first.
// Overview of operation
// - Enable code 00 keeps the sequencer idle; code 01 runs the brake sequence.
// - Release wait 0.00-5.00 s: time for current to reach release level.
// - Acceleration wait 0.00-5.00 s: mechanical delay after release output.
// - Stopping wait 0.00-5.00 s: mechanical delay after release drops.
// - Confirmation wait 0.00-5.00 s, longer than the brake's confirm delay.
// - Release frequency 0.00-99.99 Hz in hundredths, 100.0-400.0 Hz in tenths.
// - Release current level up to 2.0x rated, 1.8x on large frames.
// - Apply frequency uses the same ranges as release frequency.
// - Current below level at release wait end trips with the brake fault.
// - Confirm not rising within confirm wait while accelerating trips.
// - Confirm not falling within confirm wait while decelerating trips.
// - Confirm dropping while release output is high trips.
// - On run, reach release frequency, wait release time, then release.
// - After confirm, or release if unassigned, wait accel time, then accelerate.
// - On run removal, decelerate to apply frequency, then drop release.
// - After confirm clears, or release drops, wait stop time, then go to 0 Hz.
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "brs_map.svh"
module brs_seq #(
	parameter int TICK_CYCLES = `BRS_TICK_CYCLES
) (
	input logic core_clk,
	input logic srst,
	input brs_pkg::brs_addr_t reg_addr,
	input brs_pkg::brs_word_t reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	output brs_pkg::brs_word_t reg_rdata,
	input logic run_cmd,
	input brs_pkg::brs_word_t out_freq,
	input brs_pkg::brs_word_t out_current,
	input logic brake_confirm_in,
	output logic brake_release_out,
	output logic brake_error_out,
	output logic freq_hold,
	output logic trip,
	output logic [7:0] brake_fault_code,
	output logic irq
);
	import brs_pkg::*;

	function automatic brs_time_t clamp_time(input brs_word_t v);
		clamp_time = (v > 16'(`BRS_TIME_MAX)) ? `BRS_TIME_MAX : v[8:0];
	endfunction : clamp_time

	// Above 100 Hz only tenths are kept, so the low hundredth is dropped
	function automatic brs_word_t quant_freq(input brs_word_t v);
		brs_word_t c;
		c = (v > `BRS_FREQ_MAX) ? `BRS_FREQ_MAX : v;
		quant_freq = (c >= `BRS_FREQ_FINE_TOP) ? c - (c % `BRS_FREQ_COARSE_STEP) : c;
	endfunction : quant_freq

	// Registers
	brs_word_t ctrl_q;
	brs_time_t release_wait_time_q, accel_wait_time_q, stop_wait_time_q, confirm_wait_time_q;
	brs_word_t release_frequency_q, release_current_level_q, apply_frequency_q;
	logic [`BRS_IRQ_W-1:0] irq_stat_q, irq_mask_q;
	brs_word_t rdata_q;
	brs_state_t state_q, state_d;
	logic release_q, release_d;
	logic error_q, hold_q;
	logic conf_meta_q, conf_sync_q;

	wire wr_ctrl = reg_wr & (reg_addr == `BRS_REG_CTRL);
	wire wr_irq_stat = reg_wr & (reg_addr == `BRS_REG_IRQ_STAT);
	wire [1:0] brake_seq_enable = ctrl_q[`BRS_CTRL_EN_HI:`BRS_CTRL_EN_LO];
	wire seq_on = (brake_seq_enable == `BRS_EN_ON);
	wire conf_assigned = ctrl_q[`BRS_CTRL_CONF_ASSIGNED];
	wire fault_clear = wr_ctrl & reg_wdata[`BRS_CTRL_FAULT_CLEAR];
	wire brs_word_t cur_max = ctrl_q[`BRS_CTRL_LARGE_FRAME] ? `BRS_CUR_MAX_LARGE : `BRS_CUR_MAX;
	wire brs_word_t cur_in = (reg_wdata > cur_max) ? cur_max : reg_wdata;

	// Register writes; fault_clear is a strobe and is not stored
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ctrl_q <= `BRS_RST_CTRL;
			release_wait_time_q <= '0;
			accel_wait_time_q <= '0;
			stop_wait_time_q <= '0;
			confirm_wait_time_q <= '0;
			release_frequency_q <= `BRS_RST_WORD;
			release_current_level_q <= `BRS_RST_WORD;
			apply_frequency_q <= `BRS_RST_WORD;
			irq_mask_q <= '0;
		end else if (reg_wr) begin
			case (reg_addr)
				`BRS_REG_CTRL: ctrl_q <= reg_wdata & ~(16'h0001 << `BRS_CTRL_FAULT_CLEAR);
				`BRS_REG_IRQ_MASK: irq_mask_q <= reg_wdata[`BRS_IRQ_W-1:0];
				`BRS_REG_REL_WAIT: release_wait_time_q <= clamp_time(reg_wdata);
				`BRS_REG_ACC_WAIT: accel_wait_time_q <= clamp_time(reg_wdata);
				`BRS_REG_STOP_WAIT: stop_wait_time_q <= clamp_time(reg_wdata);
				`BRS_REG_CONF_WAIT: confirm_wait_time_q <= clamp_time(reg_wdata);
				`BRS_REG_REL_FREQ: release_frequency_q <= quant_freq(reg_wdata);
				`BRS_REG_REL_CUR: release_current_level_q <= cur_in;
				`BRS_REG_APPLY_FREQ: apply_frequency_q <= quant_freq(reg_wdata);
				default: ;
			endcase
		end
	end

	// Confirm pin synchroniser
	always_ff @(posedge core_clk) begin
		if (srst) begin
			conf_meta_q <= 1'b0;
			conf_sync_q <= 1'b0;
		end else begin
			conf_meta_q <= brake_confirm_in;
			conf_sync_q <= conf_meta_q;
		end
	end

	// Phase timer
	logic tick, tmr_exp;
	wire tmr_start = (state_d != state_q);
	brs_time_t tmr_limit;
	assign tmr_limit = (state_q == ST_REL_WAIT) ? release_wait_time_q :
		(state_q == ST_ACC_WAIT) ? accel_wait_time_q :
		(state_q == ST_STOP_WAIT) ? stop_wait_time_q : confirm_wait_time_q;

	brs_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
		.core_clk(core_clk),
		.srst(srst),
		.restart(tmr_start),
		.tick(tick)
	);

	brs_timer u_timer (
		.core_clk(core_clk),
		.srst(srst),
		.start(tmr_start),
		.tick(tick),
		.limit(tmr_limit),
		.expired(tmr_exp)
	);

	wire cur_ok = (out_current >= release_current_level_q);
	wire at_release_freq = (out_freq >= release_frequency_q);
	wire at_apply_freq = (out_freq <= apply_frequency_q);
	// Confirm only watched once it has been seen high
	wire conf_lost = conf_assigned & ~conf_sync_q & release_q &
		((state_q == ST_ACC_WAIT) | (state_q == ST_RUN) | (state_q == ST_DEC_APPLY));

	always_comb begin
		state_d = state_q;
		release_d = release_q;
		case (state_q)
			ST_IDLE: begin
				release_d = 1'b0;
				if (seq_on && run_cmd) state_d = ST_ACC_REL;
			end
			ST_ACC_REL: begin
				if (!run_cmd || !seq_on) state_d = ST_IDLE;
				else if (at_release_freq) state_d = ST_REL_WAIT;
			end
			ST_REL_WAIT: begin
				if (tmr_exp) begin
					if (cur_ok) begin
						release_d = 1'b1;
						state_d = conf_assigned ? ST_CONF_ON : ST_ACC_WAIT;
					end else begin
						state_d = ST_FAULT;
					end
				end
			end
			ST_CONF_ON: begin
				if (conf_sync_q) state_d = ST_ACC_WAIT;
				else if (tmr_exp) state_d = ST_FAULT;
			end
			ST_ACC_WAIT: begin
				if (conf_lost) state_d = ST_FAULT;
				else if (tmr_exp) state_d = ST_RUN;
			end
			ST_RUN: begin
				if (conf_lost) state_d = ST_FAULT;
				else if (!run_cmd) state_d = ST_DEC_APPLY;
			end
			ST_DEC_APPLY: begin
				if (conf_lost) begin
					state_d = ST_FAULT;
				end else if (at_apply_freq) begin
					release_d = 1'b0;
					state_d = conf_assigned ? ST_CONF_OFF : ST_STOP_WAIT;
				end
			end
			ST_CONF_OFF: begin
				if (!conf_sync_q) state_d = ST_STOP_WAIT;
				else if (tmr_exp) state_d = ST_FAULT;
			end
			ST_STOP_WAIT: begin
				if (tmr_exp) state_d = ST_DEC_ZERO;
			end
			ST_DEC_ZERO: begin
				if (out_freq == '0) state_d = ST_IDLE;
			end
			ST_FAULT: begin
				release_d = 1'b0;
				if (fault_clear && !run_cmd) state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
				release_d = 1'b0;
			end
		endcase
		if (state_d == ST_FAULT) release_d = 1'b0;
	end

	// Drive holds frequency while the brake is in transition
	wire hold_d = (state_d == ST_REL_WAIT) | (state_d == ST_CONF_ON) |
		(state_d == ST_ACC_WAIT) | (state_d == ST_CONF_OFF) | (state_d == ST_STOP_WAIT) |
		((state_d == ST_ACC_REL) & at_release_freq) |
		((state_d == ST_DEC_APPLY) & at_apply_freq);

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_q <= ST_IDLE;
			release_q <= 1'b0;
			error_q <= 1'b0;
			hold_q <= 1'b0;
		end else begin
			state_q <= state_d;
			release_q <= release_d;
			error_q <= (state_d == ST_FAULT);
			hold_q <= hold_d;
		end
	end

	assign brake_release_out = release_q;
	assign brake_error_out = error_q;
	assign trip = error_q;
	assign brake_fault_code = error_q ? `BRS_FAULT_CODE : 8'h00;
	assign freq_hold = hold_q;

	// Interrupt status: set wins over a simultaneous write-one clear
	wire [`BRS_IRQ_W-1:0] irq_set = {release_q & ~release_d, ~release_q & release_d,
		~error_q & (state_d == ST_FAULT)};
	wire [`BRS_IRQ_W-1:0] irq_clr = wr_irq_stat ? reg_wdata[`BRS_IRQ_W-1:0] : '0;
	always_ff @(posedge core_clk) begin
		if (srst) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
		end
	end
	assign irq = |(irq_stat_q & irq_mask_q);

	// Read path; unmapped addresses read zero
	wire brs_word_t status_w = {2'h0, error_q, conf_sync_q, release_q, state_q};
	wire brs_word_t rd_mux =
		(reg_addr == `BRS_REG_CTRL) ? ctrl_q :
		(reg_addr == `BRS_REG_STATUS) ? status_w :
		(reg_addr == `BRS_REG_IRQ_STAT) ? {13'h0000, irq_stat_q} :
		(reg_addr == `BRS_REG_IRQ_MASK) ? {13'h0000, irq_mask_q} :
		(reg_addr == `BRS_REG_REL_WAIT) ? {7'h00, release_wait_time_q} :
		(reg_addr == `BRS_REG_ACC_WAIT) ? {7'h00, accel_wait_time_q} :
		(reg_addr == `BRS_REG_STOP_WAIT) ? {7'h00, stop_wait_time_q} :
		(reg_addr == `BRS_REG_CONF_WAIT) ? {7'h00, confirm_wait_time_q} :
		(reg_addr == `BRS_REG_REL_FREQ) ? release_frequency_q :
		(reg_addr == `BRS_REG_REL_CUR) ? release_current_level_q :
		(reg_addr == `BRS_REG_APPLY_FREQ) ? apply_frequency_q :
		(reg_addr == `BRS_REG_FAULT_CODE) ? {8'h00, brake_fault_code} : 16'h0000;
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= reg_rd ? rd_mux : 16'h0000;
		end
	end
	assign reg_rdata = rdata_q;

	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence s_low_current_expiry;
		(state_q == ST_REL_WAIT) && tmr_exp && !cur_ok;
	endsequence
	sequence s_fault_entered;
		(state_q == ST_FAULT) && brake_error_out && !brake_release_out;
	endsequence

	chk_idle_when_off: assert property ((state_q == ST_IDLE) && !seq_on
		|=> state_q == ST_IDLE)
		else $error("sequencer left idle while disabled");
	chk_release_has_current: assert property ($rose(brake_release_out)
		|-> $past(cur_ok))
		else $error("release asserted without release current");
	chk_low_current_trip: assert property (s_low_current_expiry |=> s_fault_entered)
		else $error("low current at wait end did not trip");
	chk_confirm_on_wait: assert property (
		(state_q == ST_CONF_ON) && tmr_exp && !conf_sync_q |=> s_fault_entered)
		else $error("missing confirm did not trip");
	chk_confirm_off_wait: assert property (
		(state_q == ST_CONF_OFF) && tmr_exp && conf_sync_q |=> s_fault_entered)
		else $error("confirm stuck on did not trip");
	chk_confirm_drop_trip: assert property (conf_lost
		|=> s_fault_entered ##1 brake_error_out)
		else $error("confirm drop under release did not trip");
	chk_drop_at_apply: assert property (
		(state_q == ST_DEC_APPLY) && at_apply_freq && !conf_lost |=> !brake_release_out)
		else $error("release not dropped at apply frequency");
	chk_skip_confirm: assert property ($rose(brake_release_out) && !conf_assigned
		|-> state_q == ST_ACC_WAIT)
		else $error("confirm phase not skipped");
	chk_release_held_run: assert property ((state_q == ST_RUN) |-> brake_release_out)
		else $error("running with brake engaged");
	chk_timer_restart: assert property (tmr_start && (state_d != ST_IDLE)
		|=> !tmr_exp || tmr_limit == '0)
		else $error("timer not restarted on phase entry");
	chk_stop_before_zero: assert property ((state_q == ST_STOP_WAIT) && !tmr_exp
		|=> state_q != ST_DEC_ZERO)
		else $error("zero decel before stop wait expired");
endmodule : brs_seq

// ==== rtl/brs_tick.sv ====
// Purpose: 10 ms tick generator, restartable at each phase entry.
// Assumes: Restart aligns the first tick a full period after it.
// Notes: Period is a parameter so simulation can shorten it.
`timescale 1ns/1ps
`include "brs_map.svh"
module brs_tick #(
	parameter int TICK_CYCLES = `BRS_TICK_CYCLES
) (
	input logic core_clk,
	input logic srst,
	input logic restart,
	output logic tick
);
	import brs_pkg::*;
	localparam logic [`BRS_TICK_CNT_W-1:0] LAST = `BRS_TICK_CNT_W'(TICK_CYCLES - 1);
	logic [`BRS_TICK_CNT_W-1:0] cnt_q;
	wire at_last = (cnt_q == LAST);
	assign tick = at_last & ~restart;
	always_ff @(posedge core_clk) begin
		if (srst || restart || at_last) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
endmodule : brs_tick

// ==== rtl/brs_timer.sv ====
// Purpose: Phase wait timer counting 10 ms ticks up to a limit.
// Assumes: start pulses in the cycle the phase is entered.
// Notes: A zero limit expires one cycle after entry.
`timescale 1ns/1ps
`include "brs_map.svh"
module brs_timer (
	input logic core_clk,
	input logic srst,
	input logic start,
	input logic tick,
	input brs_pkg::brs_time_t limit,
	output logic expired
);
	import brs_pkg::*;
	brs_time_t cnt_q;
	// Count only: start comes from the next-state logic, so masking with it would close a loop
	assign expired = (cnt_q >= limit);
	always_ff @(posedge core_clk) begin
		if (srst || start) begin
			cnt_q <= '0;
		end else if (tick && cnt_q < limit) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
endmodule : brs_timer

// ==== verif/brake_release_sequencer_bench.sv ====
// Purpose: Self-checking bench for the brake release sequencer.
// Assumes: TICK_CYCLES of 4, so one wait unit is 4 cycles.
// Notes: Drive-side frequency and current are stepped by hand.
`timescale 1ns/1ps
`include "brs_map.svh"
module brake_release_sequencer_bench;
	import brs_pkg::*;
	localparam int TC = 4;
	localparam int O_REL = 0;
	localparam int O_ERR = 1;
	localparam int O_HOLD = 2;
	// Both above the drive start frequency
	localparam brs_word_t REL_F = 16'h01F4;
	localparam brs_word_t APPLY_F = 16'h00C8;
	typedef struct {
		brs_addr_t a;
		brs_word_t d;
		brs_word_t e;
	} brs_row_t;
	brs_row_t rows[13] = '{
		'{4'h4, 16'h01F4, 16'h01F4}, '{4'h4, 16'h01F5, 16'h01F4},
		'{4'h5, 16'h0200, 16'h01F4}, '{4'h6, 16'h0003, 16'h0003},
		'{4'h7, 16'hFFFF, 16'h01F4}, '{4'h8, 16'h270F, 16'h270F},
		'{4'h8, 16'h2711, 16'h2710}, '{4'h8, 16'h9C41, 16'h9C40},
		'{4'h9, 16'h0800, 16'h07D0}, '{4'hA, 16'h2715, 16'h2710},
		'{4'hC, 16'h1234, 16'h0000}, '{4'hB, 16'h00FF, 16'h0000},
		'{4'h1, 16'hFFFF, 16'h0001}
	};
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	brs_addr_t reg_addr = 4'h0;
	brs_word_t reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	brs_word_t reg_rdata;
	logic run_cmd = 1'b0;
	brs_word_t out_freq = 16'h0000;
	brs_word_t out_current = 16'h0000;
	logic [1:0] fault_mode = 2'h1;
	logic brake_confirm_in, brake_release_out, brake_error_out, freq_hold, trip, irq;
	logic [7:0] brake_fault_code;
	logic [7:0] code_seen;
	logic [4:0] o;
	wire logic [4:0] obs;
	logic irq_seen;
	brs_word_t rd_q;
	int k;
	int n_errors = 0;
	int check_count = 0;
	assign obs = {trip, irq, freq_hold, brake_error_out, brake_release_out};
	brs_seq #(.TICK_CYCLES(TC)) dut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.run_cmd(run_cmd), .out_freq(out_freq), .out_current(out_current),
		.brake_confirm_in(brake_confirm_in), .brake_release_out(brake_release_out),
		.brake_error_out(brake_error_out), .freq_hold(freq_hold), .trip(trip),
		.brake_fault_code(brake_fault_code), .irq(irq));
	brs_brake_model partner (.core_clk(core_clk), .srst(srst),
		.brake_release_out(brake_release_out), .fault_mode(fault_mode),
		.brake_confirm_in(brake_confirm_in));
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic conclude();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	function automatic logic in_win(input int cyc, input int lim);
		return (cyc + 1 >= lim * TC) && (cyc + 1 <= lim * TC + 4);
	endfunction : in_win
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc
	task automatic wr(input brs_addr_t a, input brs_word_t d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask : wr
	task automatic rd(input brs_addr_t a, output brs_word_t d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
		irq_seen = irq;
		@(posedge core_clk);
	endtask : rd
	task automatic look();
		@(negedge core_clk);
		o = obs;
		code_seen = brake_fault_code;
		@(posedge core_clk);
	endtask : look
	// Counts cycles into k; gives up after bound so a hang cannot stall the run
	task automatic wait_obs(input int i, input logic v, input int bound);
		k = 0;
		@(negedge core_clk);
		while (obs[i] !== v && k < bound) begin
			@(negedge core_clk);
			k++;
		end
		check("wait_output", obs[i], v);
		if (obs[i] !== v) begin
			conclude();
		end else begin
			@(posedge core_clk);
		end
	endtask : wait_obs
	task automatic run_up(input brs_word_t cur);
		out_current <= cur;
		out_freq <= REL_F;
		run_cmd <= 1'b1;
		wait_obs(O_HOLD, 1'b1, 20);
	endtask : run_up
	task automatic clear_fault(input brs_word_t ctrl);
		run_cmd <= 1'b0;
		wr(4'h0, ctrl | 16'h0010);
		look();
		check("fault_cleared", o[O_ERR], 1'b0);
	endtask : clear_fault
	initial begin
		repeat (20000) @(posedge core_clk);
		check("watchdog", 1'b0, 1'b1);
		conclude();
	end
	initial begin
		repeat (8) @(posedge core_clk);
		srst <= 1'b0;
		look();
		check("outputs_after_reset", {o, code_seen}, 16'h0000);
		rd(4'h1, rd_q);
		check("status_reset", rd_q, 16'h0001);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rd_q);
			check("readback", rd_q, rows[i].e);
		end
		wr(4'h0, 16'h0008);
		wr(4'h9, 16'h0800);
		rd(4'h9, rd_q);
		check("current_large_frame", rd_q, 16'h0708);
		wr(4'h4, 16'h0002);
		wr(4'h5, 16'h0001);
		wr(4'h6, 16'h0003);
		wr(4'h7, 16'h0004);
		wr(4'h8, REL_F);
		wr(4'h9, 16'h0100);
		wr(4'hA, APPLY_F);
		rd(4'hA, rd_q);
		check("apply_freq", rd_q, APPLY_F);
		wr(4'h3, 16'h0006);
		for (int c = 0; c < 4; c++) begin
			if (c != 1) begin
				wr(4'h0, 16'(c));
				run_cmd <= 1'b1;
				out_freq <= REL_F;
				cyc(10);
				rd(4'h1, rd_q);
				check("status_disabled", rd_q, 16'h0001);
				run_cmd <= 1'b0;
			end
		end
		// Contact left open: with confirm unassigned no check may trip
		wr(4'h0, 16'h0001);
		run_up(16'h0200);
		wait_obs(O_REL, 1'b1, 40);
		check("release_delay", in_win(k, 2), 1'b1);
		wait_obs(O_HOLD, 1'b0, 40);
		check("accel_delay", in_win(k, 1), 1'b1);
		out_freq <= 16'h1000;
		run_cmd <= 1'b0;
		cyc(10);
		look();
		check("release_above_apply", o[O_REL], 1'b1);
		out_freq <= APPLY_F;
		wait_obs(O_REL, 1'b0, 6);
		rd(4'h1, rd_q);
		check("status_stop_wait", rd_q, 16'h0100);
		cyc(14);
		rd(4'h1, rd_q);
		check("status_dec_zero", rd_q, 16'h0200);
		out_freq <= 16'h0000;
		cyc(3);
		rd(4'h2, rd_q);
		check("irq_events", rd_q, 16'h0006);
		check("irq_level", irq_seen, 1'b1);
		wr(4'h2, 16'h0006);
		rd(4'h1, rd_q);
		check("status_idle", rd_q, 16'h0001);
		check("irq_cleared", irq_seen, 1'b0);
		run_up(16'h0080);
		wait_obs(O_ERR, 1'b1, 40);
		check("error_delay", in_win(k, 2), 1'b1);
		look();
		check("fault_outputs", {o[4], o[O_REL], code_seen}, 16'h0224);
		check("irq_masked", o[3], 1'b0);
		wr(4'h3, 16'h0007);
		look();
		check("irq_unmasked", o[3], 1'b1);
		wr(4'h2, 16'h0001);
		wr(4'h0, 16'h0011);
		look();
		check("irq_w1c", o[3], 1'b0);
		check("clear_refused_in_run", o[O_ERR], 1'b1);
		clear_fault(16'h0005);
		fault_mode <= 2'h0;
		run_up(16'h0200);
		wait_obs(O_REL, 1'b1, 40);
		wait_obs(O_HOLD, 1'b0, 60);
		fault_mode <= 2'h1;
		wait_obs(O_ERR, 1'b1, 6);
		clear_fault(16'h0005);
		run_up(16'h0200);
		wait_obs(O_REL, 1'b1, 40);
		wait_obs(O_ERR, 1'b1, 40);
		check("confirm_on_timeout", in_win(k, 4), 1'b1);
		clear_fault(16'h0005);
		fault_mode <= 2'h0;
		run_up(16'h0200);
		wait_obs(O_REL, 1'b1, 40);
		wait_obs(O_HOLD, 1'b0, 60);
		fault_mode <= 2'h2;
		out_freq <= APPLY_F;
		run_cmd <= 1'b0;
		wait_obs(O_REL, 1'b0, 6);
		wait_obs(O_ERR, 1'b1, 40);
		check("confirm_off_timeout", in_win(k, 4), 1'b1);
		clear_fault(16'h0005);
		fault_mode <= 2'h1;
		wr(4'h0, 16'h0001);
		run_up(16'h0200);
		wait_obs(O_REL, 1'b1, 40);
		srst <= 1'b1;
		cyc(2);
		srst <= 1'b0;
		look();
		check("outputs_after_reset", {o, code_seen}, 16'h0000);
		rd(4'h0, rd_q);
		check("ctrl_after_reset", rd_q, 16'h0000);
		conclude();
	end
endmodule : brake_release_sequencer_bench

// ==== verif/brs_brake_model.sv ====
// Purpose: Brake actuator with its confirmation contact.
// Assumes: Contact follows the release command after DELAY cycles.
// Notes: fault_mode 1 leaves the contact open, 2 sticks it closed.
`timescale 1ns/1ps
module brs_brake_model #(
	parameter int DELAY = 3
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic brake_release_out,
	input wire logic [1:0] fault_mode,
	output logic brake_confirm_in
);
	logic [DELAY-1:0] pipe_q;
	always_ff @(posedge core_clk) begin
		if (srst) begin
			pipe_q <= '0;
		end else begin
			pipe_q <= {pipe_q[DELAY-2:0], brake_release_out};
		end
	end
	// Delay far below the confirm wait used
	assign brake_confirm_in = (fault_mode == 2'h0) ? pipe_q[DELAY-1] : (fault_mode == 2'h2);
endmodule : brs_brake_model
